// >>> hw/smapm_consts.svh
/*
 Constants of the sensor monitor, alarm and power manager: offsets, fields, reset values, timing.
 Assumes a 50 MHz core clock and byte addresses on a 32-bit AXI4-Lite bus.
*/
// Notes on behaviour
// - A measurement that cannot complete reports minus sixty-four degrees.
// - Writing sensor data word or read command starts on-demand measurement, no alarm effect.
// - Monitor runs only in battery-assist mode, checking battery, tamper, under, over.
// - Monitor needs non-zero interval; with time stamp, top clock byte non-zero.
// - Monitor keeps under count, over count and aborted measurement count.
// - Each monitor sample checks the battery and updates the low battery alarm.
// - Low battery volatile only; tamper, under and over alarms OR of volatile and non-volatile copy.
// - Sensor alarm bit of control word one is OR of all five alarms.
// - Battery checked in assist mode, per monitor pass and wake; latest result only.
// - Reader cannot set or clear the low battery alarm.
// - Tamper checked if enabled and clear, on monitor pass and wake, any mode.
// - Assist mode, tamper pin configured, not SPI slave: port line three rise checks tamper.
// - Tamper alarm non-volatile; cleared by enabled clear command or control/calibration write.
// - Latched shock event drives shock alarm when enabled; survives power cycles.
// - Enabled clear command or control/calibration write clears shock event and alarm.
// - Samples compared to thresholds; consecutive counts set alarm on reaching limit.
// - Under and over alarms non-volatile; cleared by enabled clear command.
// - With ultra-low-power enabled, assist mode write applies at ready state or reset.
// - Sleep: decoder oscillator off, detector polled at 2-bit duty setting.
// - After detection, sample every 25 us; three in a row go active, else resume.
// - Sleep to active enables decoder oscillator and starts boot.
// - Active: detector continuous; 2-bit fade setting sets return to sleep delay.
// - Tag-talks-first repeats message while field present; mutes after 6-bit count.
`ifndef SMAPM_CONSTS_SVH
`define SMAPM_CONSTS_SVH
`define SMAPM_OFF_CTRL 8'h00
`define SMAPM_OFF_INTERVAL 8'h04
`define SMAPM_OFF_THRESH 8'h08
`define SMAPM_OFF_CALIB 8'h0c
`define SMAPM_OFF_CMD 8'h10
`define SMAPM_OFF_SDATA 8'h14
`define SMAPM_OFF_STATUS 8'h18
`define SMAPM_OFF_COUNTS 8'h1c
`define SMAPM_OFF_PWR 8'h20
`define SMAPM_CMD_ALARM_CLR 1
`define SMAPM_CMD_SENSOR_READ 0
`define SMAPM_RST_CTRL 8'h00
`define SMAPM_RST_INTERVAL 16'h0000
`define SMAPM_RST_THRESH 32'h0000_0000
`define SMAPM_RST_CALIB 16'h0000
`define SMAPM_RST_PWR 11'h000
`define SMAPM_TEMP_FAIL 16'hffc0
`define SMAPM_CLK_NS 20
`define SMAPM_CONFIRM_US 25
`define SMAPM_CONFIRM_CYC ((`SMAPM_CONFIRM_US * 1000) / `SMAPM_CLK_NS)
`define SMAPM_CONFIRM_HITS 2'h3
`define SMAPM_RESP_OK 2'b00
`define SMAPM_RESP_SLVERR 2'b10
`endif

// >>> hw/smapm_pkg.sv
/*
 Types of the sensor monitor, alarm and power manager.
 Assumes smapm_consts.svh for the numeric constants.
*/
package smapm_pkg;
	typedef enum logic [1:0] {FD_SLEEP, FD_CONFIRM, FD_ACTIVE, FD_FADE} smapm_fd_t;
	typedef struct packed {
		logic aux_tamper_cfg;
		logic spi_slave;
		logic ts_req;
		logic clr_cmd_en;
		logic shock_en;
		logic tamper_en;
		logic ulp_en;
		logic bap_req;
	} smapm_ctrl_t;
	typedef struct packed {
		logic ttf_en;
		logic [5:0] mute_cnt;
		logic [1:0] fade;
		logic [1:0] duty;
	} smapm_pwr_t;
	typedef struct packed {
		logic [7:0] over_lim;
		logic [7:0] under_lim;
		logic [7:0] over_thr;
		logic [7:0] under_thr;
	} smapm_thr_t;
endpackage

// >>> hw/smapm_top.sv
/*
 Sensor monitor, alarm and power manager with an AXI4-Lite register slave.
 Assumes synchronous inputs, an external temperature converter, battery comparator,
 non-volatile alarm store, field detector and message transmitter.
*/
// The AXI4-Lite interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "smapm_consts.svh"
module smapm_top #(
	parameter int TICK_CYC = 50000,
	parameter int POLL_BASE_CYC = 12500,
	parameter int FADE_BASE_CYC = 25000
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Temperature converter
	output logic meas_start,
	input wire logic meas_done,
	input wire logic meas_ok,
	input wire logic [15:0] meas_value,
	// Battery, tamper, shock, clock
	input wire logic batt_below,
	input wire logic tamper_pin,
	input wire logic port_line_three,
	input wire logic shock_event_input,
	output logic shock_clr,
	input wire logic [31:0] time_of_day_counter,
	// Non-volatile alarms: tamper, under, over
	input wire logic [2:0] nv_alarm_q,
	output logic [2:0] nv_alarm_set,
	output logic [2:0] nv_alarm_clr,
	// Field detector and power
	input wire logic field_detect,
	input wire logic ready_state,
	output logic field_det_en,
	output logic decoder_osc_en,
	output logic boot_start,
	output logic battery_assist_mode,
	// Broadcast messages
	input wire logic msg_done,
	output logic msg_tx_req,
	output logic extended_protocol_control_word_one_alarm
);
	generate
		if (TICK_CYC < 1 || POLL_BASE_CYC < 1 || FADE_BASE_CYC < 1 ||
				POLL_BASE_CYC > 32'h0fff_ffff || FADE_BASE_CYC > 32'h0fff_ffff) begin : g_chk
			$error("smapm_top: bad timing parameter");
		end
	endgenerate

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] sat_inc(input logic [7:0] v);
		return (v == 8'hff) ? v : v + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register bus
	smapm_pkg::smapm_ctrl_t ctrl_r;
	smapm_pkg::smapm_pwr_t pwr_r;
	smapm_pkg::smapm_thr_t thr_r;
	logic [15:0] interval_r;
	logic [15:0] calib_r;
	logic [15:0] sdata_r;
	logic aw_q_r, w_q_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic [31:0] rdata_r;
	logic [1:0] bresp_r, rresp_r;
	logic bvalid_r, rvalid_r;
	logic wr_go, wr_ok, rd_ok;
	logic [31:0] rd_mux;
	logic wr_ctrl, wr_cfg, wr_cmd, wr_sdata;
	logic clr_cmd, clr_cfg;
	logic [7:0] ucnt_r, ocnt_r, acnt_r;
	logic low_batt_r, tamper_r, ut_r, ot_r;
	logic bap_eff_r, bap_pend_r;
	smapm_pkg::smapm_fd_t fd_r;
	logic muted_r;

	assign s_axi_awready = !aw_q_r && !bvalid_r;
	assign s_axi_wready = !w_q_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign wr_go = aw_q_r && w_q_r && !bvalid_r;
	assign wr_ok = awaddr_r[1:0] == 2'b00 && awaddr_r <= `SMAPM_OFF_PWR;
	assign wr_ctrl = wr_go && awaddr_r == `SMAPM_OFF_CTRL;
	assign wr_cfg = wr_go && (awaddr_r == `SMAPM_OFF_CTRL || awaddr_r == `SMAPM_OFF_INTERVAL ||
		awaddr_r == `SMAPM_OFF_THRESH || awaddr_r == `SMAPM_OFF_CALIB);
	assign wr_cmd = wr_go && awaddr_r == `SMAPM_OFF_CMD && wstrb_r[0];
	assign wr_sdata = wr_go && awaddr_r == `SMAPM_OFF_SDATA;
	assign clr_cmd = wr_cmd && wdata_r[`SMAPM_CMD_ALARM_CLR] && ctrl_r.clr_cmd_en;
	assign clr_cfg = wr_cfg;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			aw_q_r <= 1'b0;
			w_q_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `SMAPM_RESP_OK;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_q_r <= 1'b0;
				w_q_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= (wr_ok && awaddr_r != `SMAPM_OFF_STATUS &&
					awaddr_r != `SMAPM_OFF_COUNTS) ? `SMAPM_RESP_OK : `SMAPM_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ctrl_r <= `SMAPM_RST_CTRL;
			interval_r <= `SMAPM_RST_INTERVAL;
			thr_r <= `SMAPM_RST_THRESH;
			calib_r <= `SMAPM_RST_CALIB;
			pwr_r <= `SMAPM_RST_PWR;
		end else if (wr_go) begin
			unique case (awaddr_r)
				`SMAPM_OFF_CTRL: ctrl_r <= 8'(merge({24'h0, ctrl_r}, wdata_r, wstrb_r));
				`SMAPM_OFF_INTERVAL: interval_r <= 16'(merge({16'h0, interval_r}, wdata_r, wstrb_r));
				`SMAPM_OFF_THRESH: thr_r <= merge(thr_r, wdata_r, wstrb_r);
				`SMAPM_OFF_CALIB: calib_r <= 16'(merge({16'h0, calib_r}, wdata_r, wstrb_r));
				`SMAPM_OFF_PWR: pwr_r <= 11'(merge({21'h0, pwr_r}, wdata_r, wstrb_r));
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (s_axi_araddr)
			`SMAPM_OFF_CTRL: rd_mux = {24'h0, ctrl_r};
			`SMAPM_OFF_INTERVAL: rd_mux = {16'h0, interval_r};
			`SMAPM_OFF_THRESH: rd_mux = thr_r;
			`SMAPM_OFF_CALIB: rd_mux = {16'h0, calib_r};
			`SMAPM_OFF_CMD: rd_mux = 32'h0000_0000;
			`SMAPM_OFF_SDATA: rd_mux = {16'h0, sdata_r};
			`SMAPM_OFF_STATUS: rd_mux = {22'h0, muted_r, fd_r, bap_eff_r,
				extended_protocol_control_word_one_alarm,
				shock_event_input && ctrl_r.shock_en, ot_r | nv_alarm_q[2],
				ut_r | nv_alarm_q[1], tamper_r | nv_alarm_q[0], low_batt_r};
			`SMAPM_OFF_COUNTS: rd_mux = {8'h0, acnt_r, ocnt_r, ucnt_r};
			`SMAPM_OFF_PWR: rd_mux = {21'h0, pwr_r};
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `SMAPM_RESP_OK;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_mux;
			rresp_r <= rd_ok ? `SMAPM_RESP_OK : `SMAPM_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode and power-up
	logic pwrup_r, wake;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			pwrup_r <= 1'b1;
		end else begin
			pwrup_r <= 1'b0;
		end
	end
	assign wake = pwrup_r || boot_start;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			bap_eff_r <= 1'b0;
			bap_pend_r <= 1'b0;
		end else if (pwrup_r) begin
			bap_eff_r <= ctrl_r.bap_req;
			bap_pend_r <= 1'b0;
		end else if (!ctrl_r.ulp_en) begin
			bap_eff_r <= ctrl_r.bap_req;
			bap_pend_r <= 1'b0;
		end else if (wr_ctrl && wstrb_r[0] && wdata_r[0] != bap_eff_r) begin
			bap_pend_r <= 1'b1;
		end else if (bap_pend_r && ready_state) begin
			bap_eff_r <= ctrl_r.bap_req;
			bap_pend_r <= 1'b0;
		end
	end
	assign battery_assist_mode = bap_eff_r;

	////////////////////////////////////////////////////////////////////////////
	// Monitor scheduling
	logic [31:0] tick_cnt_r;
	logic [15:0] ival_cnt_r;
	logic mon_en, mon_pass;
	assign mon_en = bap_eff_r && interval_r != 16'h0000 &&
		(!ctrl_r.ts_req || time_of_day_counter[31:24] != 8'h00);
	always_ff @(posedge core_clk) begin
		if (!nrst || !mon_en) begin
			tick_cnt_r <= 32'h0;
			ival_cnt_r <= 16'h0;
		end else if (tick_cnt_r == 32'(TICK_CYC - 1)) begin
			tick_cnt_r <= 32'h0;
			ival_cnt_r <= (ival_cnt_r >= interval_r - 16'h1) ? 16'h0 : ival_cnt_r + 16'h1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h1;
		end
	end
	assign mon_pass = mon_en && tick_cnt_r == 32'(TICK_CYC - 1) &&
		ival_cnt_r >= interval_r - 16'h1;

	////////////////////////////////////////////////////////////////////////////
	// Temperature measurement
	logic busy_r, own_mon_r, od_pend_r, mon_pend_r, start_r;
	logic od_req;
	logic [15:0] result;
	assign od_req = wr_sdata || (wr_cmd && wdata_r[`SMAPM_CMD_SENSOR_READ]);
	assign result = meas_ok ? meas_value : `SMAPM_TEMP_FAIL;
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			busy_r <= 1'b0;
			own_mon_r <= 1'b0;
			od_pend_r <= 1'b0;
			mon_pend_r <= 1'b0;
			start_r <= 1'b0;
			sdata_r <= `SMAPM_TEMP_FAIL;
		end else begin
			start_r <= 1'b0;
			if (od_req) begin
				od_pend_r <= 1'b1;
			end
			if (mon_pass) begin
				mon_pend_r <= 1'b1;
			end
			if (busy_r && meas_done) begin
				busy_r <= 1'b0;
				if (!own_mon_r) begin
					sdata_r <= result;
				end
			end else if (!busy_r && od_pend_r) begin
				busy_r <= 1'b1;
				own_mon_r <= 1'b0;
				od_pend_r <= od_req;
				start_r <= 1'b1;
			end else if (!busy_r && mon_pend_r) begin
				busy_r <= 1'b1;
				own_mon_r <= 1'b1;
				mon_pend_r <= mon_pass;
				start_r <= 1'b1;
			end
		end
	end
	assign meas_start = start_r;

	////////////////////////////////////////////////////////////////////////////
	// Monitor results and alarms
	logic mon_done, below, above, ut_hit, ot_hit, tamper_hit, p3_r, p3_rise, tamper_rep;
	assign mon_done = busy_r && meas_done && own_mon_r && bap_eff_r;
	assign below = $signed(meas_value) < $signed({{8{thr_r.under_thr[7]}}, thr_r.under_thr});
	assign above = $signed(meas_value) > $signed({{8{thr_r.over_thr[7]}}, thr_r.over_thr});
	assign ut_hit = mon_done && meas_ok && below && sat_inc(ucnt_r) >= thr_r.under_lim;
	assign ot_hit = mon_done && meas_ok && above && sat_inc(ocnt_r) >= thr_r.over_lim;

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ucnt_r <= 8'h00;
			ocnt_r <= 8'h00;
			acnt_r <= 8'h00;
		end else if (mon_done) begin
			if (!meas_ok) begin
				acnt_r <= sat_inc(acnt_r);
			end else begin
				ucnt_r <= below ? sat_inc(ucnt_r) : 8'h00;
				ocnt_r <= above ? sat_inc(ocnt_r) : 8'h00;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			low_batt_r <= 1'b0;
		end else if (bap_eff_r && (mon_pass || wake)) begin
			low_batt_r <= batt_below;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			p3_r <= 1'b0;
		end else begin
			p3_r <= port_line_three;
		end
	end
	assign p3_rise = port_line_three && !p3_r && bap_eff_r && ctrl_r.aux_tamper_cfg &&
		!ctrl_r.spi_slave;
	assign tamper_rep = tamper_r | nv_alarm_q[0];
	assign tamper_hit = ctrl_r.tamper_en && !tamper_rep && tamper_pin &&
		(mon_pass || wake || p3_rise);

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			tamper_r <= 1'b0;
			ut_r <= 1'b0;
			ot_r <= 1'b0;
		end else begin
			tamper_r <= tamper_hit || (tamper_r && !(clr_cmd || clr_cfg));
			ut_r <= ut_hit || (ut_r && !clr_cmd);
			ot_r <= ot_hit || (ot_r && !clr_cmd);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			nv_alarm_set <= 3'b000;
			nv_alarm_clr <= 3'b000;
			shock_clr <= 1'b0;
		end else begin
			nv_alarm_set <= {ot_hit, ut_hit, tamper_hit};
			nv_alarm_clr <= {clr_cmd && !ot_hit, clr_cmd && !ut_hit,
				(clr_cmd || clr_cfg) && !tamper_hit};
			shock_clr <= clr_cmd || clr_cfg;
		end
	end

	assign extended_protocol_control_word_one_alarm = low_batt_r | tamper_rep |
		(shock_event_input && ctrl_r.shock_en) | ut_r | nv_alarm_q[1] |
		ot_r | nv_alarm_q[2];

	////////////////////////////////////////////////////////////////////////////
	// Field detector
	logic [31:0] fd_cnt_r;
	logic [1:0] hits_r;
	logic fd_tick, fd_sample;
	assign fd_tick = (fd_r == smapm_pkg::FD_SLEEP) ?
		fd_cnt_r >= ((32'(POLL_BASE_CYC) << pwr_r.duty) - 32'h1) :
		(fd_r == smapm_pkg::FD_CONFIRM) ? fd_cnt_r >= 32'(`SMAPM_CONFIRM_CYC - 1) :
		fd_cnt_r >= ((32'(FADE_BASE_CYC) << pwr_r.fade) - 32'h1);
	assign fd_sample = fd_r != smapm_pkg::FD_SLEEP || fd_tick;
	assign field_det_en = fd_sample;
	assign decoder_osc_en = fd_r inside {smapm_pkg::FD_ACTIVE, smapm_pkg::FD_FADE};

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			fd_r <= smapm_pkg::FD_SLEEP;
			fd_cnt_r <= 32'h0;
			hits_r <= 2'h0;
			boot_start <= 1'b0;
		end else begin
			boot_start <= 1'b0;
			fd_cnt_r <= fd_tick ? 32'h0 : fd_cnt_r + 32'h1;
			unique case (fd_r)
				smapm_pkg::FD_SLEEP: begin
					if (fd_tick && field_detect) begin
						fd_r <= smapm_pkg::FD_CONFIRM;
						fd_cnt_r <= 32'h0;
						hits_r <= 2'h0;
					end
				end
				smapm_pkg::FD_CONFIRM: begin
					if (fd_tick) begin
						if (!field_detect) begin
							fd_r <= smapm_pkg::FD_SLEEP;
						end else if (hits_r == `SMAPM_CONFIRM_HITS - 2'h1) begin
							fd_r <= smapm_pkg::FD_ACTIVE;
							boot_start <= 1'b1;
						end else begin
							hits_r <= hits_r + 2'h1;
						end
					end
				end
				smapm_pkg::FD_ACTIVE: begin
					fd_cnt_r <= 32'h0;
					if (!field_detect) begin
						fd_r <= smapm_pkg::FD_FADE;
					end
				end
				smapm_pkg::FD_FADE: begin
					if (field_detect) begin
						fd_r <= smapm_pkg::FD_ACTIVE;
					end else if (fd_tick) begin
						fd_r <= smapm_pkg::FD_SLEEP;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Broadcast messages
	logic [5:0] msg_cnt_r;
	always_ff @(posedge core_clk) begin
		if (!nrst || fd_r == smapm_pkg::FD_SLEEP) begin
			msg_cnt_r <= 6'h00;
			muted_r <= 1'b0;
		end else if (msg_done && msg_tx_req) begin
			msg_cnt_r <= msg_cnt_r + 6'h01;
			if (pwr_r.mute_cnt != 6'h00 && msg_cnt_r + 6'h01 >= pwr_r.mute_cnt) begin
				muted_r <= 1'b1;
			end
		end
	end
	assign msg_tx_req = pwr_r.ttf_en && fd_r == smapm_pkg::FD_ACTIVE && !muted_r;
endmodule // smapm_top

// >>> test/smapm_top_sva.sv
/*
 Concurrent checks on the ports of smapm_top.
 Assumes binding into smapm_top, one clock and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module smapm_top_sva (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Register bus
	input wire logic s_axi_awready,
	input wire logic s_axi_arready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Sensor, alarms, power
	input wire logic meas_start,
	input wire logic [2:0] nv_alarm_q,
	input wire logic [2:0] nv_alarm_set,
	input wire logic [2:0] nv_alarm_clr,
	input wire logic field_det_en,
	input wire logic decoder_osc_en,
	input wire logic boot_start,
	input wire logic msg_tx_req,
	input wire logic extended_protocol_control_word_one_alarm
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("aw taken during response");
	chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar taken during response");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response dropped early");
	chk_start_pulse: assert property (meas_start |=> !meas_start)
		else $error("start pulse too long");
	chk_nv_alarm_or: assert property (nv_alarm_q != 3'h0 |-> extended_protocol_control_word_one_alarm)
		else $error("stored alarm not in flag");
	chk_clr_kind: assert property (|nv_alarm_clr[2:1] |->
		(nv_alarm_clr | nv_alarm_set) == 3'h7) else $error("bad clear kind");
	chk_set_wins: assert property ((nv_alarm_set & nv_alarm_clr) == 3'h0)
		else $error("set and clear together");
	chk_osc_det: assert property (decoder_osc_en |-> field_det_en)
		else $error("detector idle while awake");
	chk_boot_wake: assert property (boot_start |-> ##[0:1] decoder_osc_en)
		else $error("boot without oscillator");
	chk_msg_awake: assert property (msg_tx_req |-> decoder_osc_en)
		else $error("message request while asleep");
endmodule // smapm_top_sva
////////////////////////////////
bind smapm_top smapm_top_sva smapm_top_sva_inst (.*);

// >>> test/smapm_sensor_model.sv
/*
 Temperature converter and field source beside smapm_top.
 Assumes the bench sets failure, speed, value and field presence.
*/
`timescale 1ns/1ps
module smapm_sensor_model (
	// Clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Bench controls
	input wire logic fail,
	input wire logic slow,
	input wire logic field_on,
	input wire logic [15:0] value,
	// Converter and field
	input wire logic meas_start,
	output logic meas_done,
	output logic meas_ok,
	output logic [15:0] meas_value,
	output logic field_detect
);
	int cnt_r;
	always_ff @(posedge core_clk) begin
		meas_done <= 1'b0;
		meas_ok <= ~meas_ok;
		meas_value <= ~meas_value;
		if (!nrst) begin
			cnt_r <= 0;
			meas_ok <= 1'b0;
			meas_value <= 16'h0000;
		end else if (meas_start) begin
			cnt_r <= slow ? 20 : 2;
		end else if (cnt_r > 0) begin
			cnt_r <= cnt_r - 1;
			if (cnt_r == 1) begin
				meas_done <= 1'b1;
				meas_ok <= !fail;
				meas_value <= value;
			end
		end
	end
	// Field held up while a conversion is pending
	assign field_detect = field_on || (cnt_r != 0);
endmodule // smapm_sensor_model

// >>> test/tb_smapm_top.sv
/*
 Self-checking bench for smapm_top: register tasks and a scenario sequence.
 Assumes smapm_sensor_model on the converter side and the bound checker.
*/
`timescale 1ns/1ps
`include "smapm_consts.svh"
module tb_smapm_top;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, time_of_day_counter = 32'h0, rdat, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, batt_below = 1'b0, tamper_pin = 1'b0;
	logic port_line_three = 1'b0, shock_event_input = 1'b0, ready_state = 1'b0;
	logic msg_done = 1'b0, fail = 1'b0, slow = 1'b0, field_on = 1'b0;
	logic [2:0] nv_alarm_q = 3'h0, nv_alarm_set, nv_alarm_clr;
	logic [15:0] value = 16'h0000, meas_value;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic meas_start, meas_done, meas_ok, field_detect, shock_clr, field_det_en;
	logic decoder_osc_en, boot_start, battery_assist_mode, msg_tx_req;
	logic extended_protocol_control_word_one_alarm;
	int bad_count = 0, compares = 0, boots = 0, shocks = 0, k;
	smapm_top #(.TICK_CYC(4), .POLL_BASE_CYC(8), .FADE_BASE_CYC(8)) smapm_top_inst (.*);
	smapm_sensor_model smapm_sensor_model_inst (.*);
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		if (boot_start === 1'b1) boots++;
		if (shock_clr === 1'b1) shocks++;
	end
	////////////////////////////////
	task automatic finish_test();
		$display("Counts: %0d mismatches in %0d compares", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask
	task automatic hang(input string m);
		chk(32'h1, 32'h0, m);
		finish_test();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (n > 100) hang("write hang");
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(32'(s_axi_bresp), 32'(er), "bresp");
	endtask
	task automatic rd(input logic [7:0] a, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (n > 100) hang("read hang");
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		rdat = s_axi_rdata;
		chk(32'(s_axi_rresp), 32'(er), "rresp");
	endtask
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		int n;
		n = 0;
		do begin
			rd(a, `SMAPM_RESP_OK);
			n++;
			if (n > 2000) hang("poll hang");
		end while ((rdat & m) !== e);
	endtask
	////////////////////////////////
	initial begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		rd(`SMAPM_OFF_SDATA, `SMAPM_RESP_OK);
		chk(rdat & 32'hffff, 32'(`SMAPM_TEMP_FAIL), "sdata reset");
		rd(8'h24, `SMAPM_RESP_SLVERR);
		chk(rdat, 32'h0, "unmapped data");
		wr(`SMAPM_OFF_STATUS, 32'h0, `SMAPM_RESP_SLVERR);
		// On-demand results, slow then failed
		wr(`SMAPM_OFF_THRESH, 32'h0203_320a, `SMAPM_RESP_OK);
		slow <= 1'b1;
		value <= 16'h0005;
		wr(`SMAPM_OFF_SDATA, 32'h0, `SMAPM_RESP_OK);
		poll(`SMAPM_OFF_SDATA, 32'hffff, 32'h0005);
		chk(32'(extended_protocol_control_word_one_alarm), 32'h0, "no alarm");
		fail <= 1'b1;
		slow <= 1'b0;
		wr(`SMAPM_OFF_CMD, 32'h1 << `SMAPM_CMD_SENSOR_READ, `SMAPM_RESP_OK);
		poll(`SMAPM_OFF_SDATA, 32'hffff, 32'(`SMAPM_TEMP_FAIL));
		// Zero interval, tamper by port line edge
		batt_below <= 1'b1;
		tamper_pin <= 1'b1;
		wr(`SMAPM_OFF_CTRL, 32'h95, `SMAPM_RESP_OK);
		repeat (40) @(posedge core_clk);
		rd(`SMAPM_OFF_STATUS, `SMAPM_RESP_OK);
		chk(rdat & 32'h43, 32'h40, "idle monitor");
		port_line_three <= 1'b1;
		poll(`SMAPM_OFF_STATUS, 32'h2, 32'h2);
		port_line_three <= 1'b0;
		wr(`SMAPM_OFF_CALIB, 32'h0, `SMAPM_RESP_OK);
		tamper_pin <= 1'b0;
		rd(`SMAPM_OFF_STATUS, `SMAPM_RESP_OK);
		chk(rdat & 32'h2, 32'h0, "tamper cleared");
		// Time stamp gate, battery check
		wr(`SMAPM_OFF_CTRL, 32'hb5, `SMAPM_RESP_OK);
		wr(`SMAPM_OFF_INTERVAL, 32'h1, `SMAPM_RESP_OK);
		repeat (40) @(posedge core_clk);
		rd(`SMAPM_OFF_STATUS, `SMAPM_RESP_OK);
		chk(rdat & 32'h1, 32'h0, "clock not set");
		time_of_day_counter <= 32'h0100_0000;
		poll(`SMAPM_OFF_STATUS, 32'h1, 32'h1);
		wr(`SMAPM_OFF_CMD, 32'h1 << `SMAPM_CMD_ALARM_CLR, `SMAPM_RESP_OK);
		rd(`SMAPM_OFF_STATUS, `SMAPM_RESP_OK);
		chk(rdat & 32'h1, 32'h1, "battery alarm kept");
		rd(`SMAPM_OFF_COUNTS, `SMAPM_RESP_OK);
		chk(32'(rdat[23:16] != 8'h00), 32'h1, "aborts");
		batt_below <= 1'b0;
		poll(`SMAPM_OFF_STATUS, 32'h1, 32'h0);
		// Under and over limits
		fail <= 1'b0;
		poll(`SMAPM_OFF_STATUS, 32'h4, 32'h4);
		chk(32'(extended_protocol_control_word_one_alarm), 32'h1, "alarm or");
		value <= 16'h0014;
		poll(`SMAPM_OFF_COUNTS, 32'hff, 32'h0);
		chk(rdat & 32'hff00, 32'h0, "over count");
		rd(`SMAPM_OFF_STATUS, `SMAPM_RESP_OK);
		chk(rdat & 32'h4, 32'h4, "under kept");
		value <= 16'h0064;
		poll(`SMAPM_OFF_STATUS, 32'h8, 32'h8);
		value <= 16'h0014;
		repeat (20) @(posedge core_clk);
		wr(`SMAPM_OFF_CMD, 32'h1 << `SMAPM_CMD_ALARM_CLR, `SMAPM_RESP_OK);
		poll(`SMAPM_OFF_STATUS, 32'hc, 32'h0);
		chk(32'(extended_protocol_control_word_one_alarm), 32'h0, "alarm or");
		nv_alarm_q <= 3'h2;
		poll(`SMAPM_OFF_STATUS, 32'h4, 32'h4);
		nv_alarm_q <= 3'h0;
		// Shock latch and clearing write
		wr(`SMAPM_OFF_CTRL, 32'hbd, `SMAPM_RESP_OK);
		shock_event_input <= 1'b1;
		poll(`SMAPM_OFF_STATUS, 32'h10, 32'h10);
		k = shocks;
		wr(`SMAPM_OFF_CALIB, 32'h0, `SMAPM_RESP_OK);
		repeat (3) @(posedge core_clk);
		chk(32'(shocks > k), 32'h1, "shock clear");
		shock_event_input <= 1'b0;
		// Wake, messages, fade to sleep
		wr(`SMAPM_OFF_INTERVAL, 32'h0, `SMAPM_RESP_OK);
		wr(`SMAPM_OFF_PWR, 32'h0420, `SMAPM_RESP_OK);
		poll(`SMAPM_OFF_STATUS, 32'h100, 32'h0);
		k = boots;
		field_on <= 1'b1;
		poll(`SMAPM_OFF_STATUS, 32'h180, 32'h100);
		chk(32'(decoder_osc_en), 32'h1, "oscillator on");
		chk(32'(boots > k), 32'h1, "boot");
		chk(32'(msg_tx_req), 32'h1, "message request");
		chk(32'(field_det_en), 32'h1, "detector on");
		repeat (2) begin
			msg_done <= 1'b1;
			@(posedge core_clk);
			msg_done <= 1'b0;
			@(posedge core_clk);
		end
		chk(32'(msg_tx_req), 32'h0, "self mute");
		field_on <= 1'b0;
		poll(`SMAPM_OFF_STATUS, 32'h100, 32'h0);
		chk(32'(decoder_osc_en), 32'h0, "oscillator off");
		// Low-power switch pends until ready
		wr(`SMAPM_OFF_CTRL, 32'hbf, `SMAPM_RESP_OK);
		wr(`SMAPM_OFF_CTRL, 32'hbe, `SMAPM_RESP_OK);
		repeat (5) @(posedge core_clk);
		chk(32'(battery_assist_mode), 32'h1, "assist held");
		ready_state <= 1'b1;
		@(posedge core_clk);
		ready_state <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(32'(battery_assist_mode), 32'h0, "assist applied");
		finish_test();
	end
endmodule // tb_smapm_top
